// File: clkgen_ctrl_pkg.sv
// Constants and types of the serial control port.
package clkgen_ctrl_pkg;

   // ----------------------------------------------------------------------
   // Bank geometry and link addressing.
   // ----------------------------------------------------------------------
   localparam int         NUM_REGS                 = 5;
   localparam int         REG_AW                   = 3;
   localparam logic [2:0] IDX_FREQ_SELECT_CONTROL  = 3'h0;
   localparam logic [2:0] IDX_CPU_CLOCK_ENABLES    = 3'h1;
   localparam logic [2:0] IDX_PCI_CLOCK_ENABLES    = 3'h2;
   localparam logic [2:0] IDX_MEMORY_CLOCK_ENABLES = 3'h3;
   localparam logic [2:0] IDX_EXTRA_CLOCK_ENABLES  = 3'h4;
   localparam logic [2:0] IDX_LAST                 = 3'h4;
   localparam logic [6:0] SLAVE_ADDR7              = 7'h69;  // Write byte D2, read byte D3.
   localparam logic       DIR_READ                 = 1'b1;
   localparam logic [7:0] UNMAPPED_READ            = 8'h00;

   // ----------------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------------
   localparam int FSC_TRISTATE_BIT  = 0;
   localparam int FSC_SPREAD_EN_BIT = 1;
   localparam int FSC_CODE_MSB_BIT  = 2;
   localparam int FSC_SOFT_SEL_BIT  = 3;
   localparam int FSC_CODE_LO_LSB   = 4;
   localparam int FSC_DEPTH_BIT     = 7;
   localparam int CPU_STRAP_BIT     = 0;
   localparam int CPU_EN_LSB        = 1;
   localparam int PCI_FREE_BIT      = 6;
   localparam int PCI_STRAP_BIT     = 7;
   localparam int EXTRA_USB_BIT     = 5;
   localparam int EXTRA_SIO_BIT     = 6;

   // ----------------------------------------------------------------------
   // Power-up values and writable bit masks.
   // ----------------------------------------------------------------------
   localparam logic [7:0] RST_FREQ_SELECT_CONTROL  = 8'h00;
   localparam logic [7:0] RST_CPU_CLOCK_ENABLES    = 8'hFF;
   localparam logic [7:0] RST_PCI_CLOCK_ENABLES    = 8'hFF;
   localparam logic [7:0] RST_MEMORY_CLOCK_ENABLES = 8'hFF;
   localparam logic [7:0] RST_EXTRA_CLOCK_ENABLES  = 8'hFF;
   localparam logic [7:0] WMASK_FREQ_SELECT        = 8'hFF;
   localparam logic [7:0] WMASK_CPU_CLOCK          = 8'h0E;
   localparam logic [7:0] WMASK_PCI_CLOCK          = 8'h5F;
   localparam logic [7:0] WMASK_MEMORY_CLOCK       = 8'hFF;
   localparam logic [7:0] WMASK_EXTRA_CLOCK        = 8'h7F;

   // Cycles after reset before straps are trusted.
   localparam logic [1:0] STRAP_SETTLE_CYCLES      = 2'h3;

   // ----------------------------------------------------------------------
   // Types.
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_RX     = 3'b001,
      ST_ACK    = 3'b010,
      ST_TX     = 3'b011,
      ST_MACK   = 3'b100,
      ST_TXLOAD = 3'b101
   } link_state_t;

   typedef enum logic [1:0] {
      STG_ADDR  = 2'b00,
      STG_CMD   = 2'b01,
      STG_COUNT = 2'b10,
      STG_DATA  = 2'b11
   } byte_stage_t;

endpackage

// File: reg_port_if.sv
// Link controller to register bank carrier.
`timescale 1ns/10ps
`default_nettype none
interface reg_port_if;
   logic        wr_en;
   logic [2:0]  addr;
   logic [7:0]  wr_data;
   logic [7:0]  rd_data;
   logic [39:0] contents;

   modport bank (input wr_en, input addr, input wr_data, output rd_data, output contents);
   modport ctrl (output wr_en, output addr, output wr_data, input rd_data, input contents);
endinterface
`default_nettype wire

// File: line_sync.sv
// Two-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module line_sync #(
   parameter int              W       = 1,
   parameter logic [W-1:0]    RST_VAL = '1
) (
   input  wire logic         i_clk,     // System clock.
   input  wire logic         i_resetn,  // Synchronous reset, active low.
   input  wire logic [W-1:0] i_async,   // Raw pin levels.
   output logic      [W-1:0] o_sync     // Levels after two flops.
);
   logic [W-1:0] meta_ff;

   // ----------------------------------------------------------------------
   // Synchroniser chain.
   // ----------------------------------------------------------------------
   // Only the second stage reads the first.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         meta_ff <= RST_VAL;
         o_sync  <= RST_VAL;
      end else begin
         meta_ff <= i_async;
         o_sync  <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// File: ctrl_reg_bank.sv
// Register bank: masked writes, strap overlay, registered read.
`timescale 1ns/10ps
`default_nettype none
module ctrl_reg_bank
   import clkgen_ctrl_pkg::*;
(
   input  wire logic       i_clk,     // System clock.
   input  wire logic       i_resetn,  // Synchronous power-up reset, active low.
   input  wire logic [1:0] i_straps,  // Latched inverted strap bits 1:0.
   reg_port_if.bank        port       // Access from the link controller.
);
   logic [7:0] regs_ff [NUM_REGS];
   logic [7:0] view    [NUM_REGS];
   logic [7:0] rst_val [NUM_REGS];
   logic [7:0] wmask   [NUM_REGS];
   logic [7:0] rd_data_ff;

   assign rst_val = '{RST_FREQ_SELECT_CONTROL, RST_CPU_CLOCK_ENABLES, RST_PCI_CLOCK_ENABLES,
                      RST_MEMORY_CLOCK_ENABLES, RST_EXTRA_CLOCK_ENABLES};
   assign wmask   = '{WMASK_FREQ_SELECT, WMASK_CPU_CLOCK, WMASK_PCI_CLOCK,
                      WMASK_MEMORY_CLOCK, WMASK_EXTRA_CLOCK};

   // ----------------------------------------------------------------------
   // Storage.
   // ----------------------------------------------------------------------
   // Only reset loads defaults; read-only and reserved bits ignore writes.
   always_ff @(posedge i_clk) begin
      for (int r = 0; r < NUM_REGS; r++) begin
         if (!i_resetn) begin
            regs_ff[r] <= rst_val[r]; // R12
         end else if (port.wr_en && port.addr == 3'(r)) begin
            regs_ff[r] <= (port.wr_data & wmask[r]) | (regs_ff[r] & ~wmask[r]); // R24
         end
      end
   end

   // Read view with the latched straps overlaid.
   always_comb begin
      for (int r = 0; r < NUM_REGS; r++) begin
         view[r] = regs_ff[r];
      end
      view[IDX_CPU_CLOCK_ENABLES][CPU_STRAP_BIT] = i_straps[0]; // R17
      view[IDX_PCI_CLOCK_ENABLES][PCI_STRAP_BIT] = i_straps[1]; // R18
   end

   // ----------------------------------------------------------------------
   // Registered read port.
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rd_data_ff <= UNMAPPED_READ;
      end else begin
         rd_data_ff <= (port.addr <= IDX_LAST) ? view[port.addr] : UNMAPPED_READ; // R1
      end
   end

   assign port.rd_data  = rd_data_ff;
   assign port.contents = {view[4], view[3], view[2], view[1], view[0]};
endmodule
`default_nettype wire

// File: clock_gen_serial_control.sv
// Serial control port and output enables of a clock synthesizer.
//
// How it works
// R1: Slave only; master may read registers back.
// R2: Writes start at register zero.
// R3: Defaults work without serial access.
// R4: Data sampled only on clock rise, stable high.
// R5: Data fall/rise with clock high: start/stop.
// R6: Eight-bit bytes, each followed by acknowledge.
// R7: Write address byte is 1101 0010.
// R8: Device pulls data low to acknowledge bytes.
// R9: Command and count bytes acked, ignored.
// R10: Data bytes fill registers zero upward.
// R11: Address byte 1101 0011 reads registers back.
// R12: Defaults load only at true power-up.
// R13: Register zero bit 0 tristates all outputs.
// R14: Register zero bit 1 enables spread spectrum.
// R15: Bit 3 picks software code over straps.
// R16: Software code is bit 2 then 6:4.
// R17: Register one: CPU enables, strap bit zero.
// R18: Register two: bus enables, strap bit one.
// R19: Register three: memory clocks 7..0.
// R20: Register four: fixed outputs, memory 12..8.
// R21: Disabled output low; no truncated high period.
// R22: Output runs only if register and pin agree.
// R23: Register zero bit 7 picks spread depth.
// R24: Reads follow write order; strap bits read-only.
`timescale 1ns/10ps
`default_nettype none
module clock_gen_serial_control
   import clkgen_ctrl_pkg::*;
#(
   parameter int NUM_PROC = 3,   // Processor clock outputs.
   parameter int NUM_BUS  = 5,   // Gated bus clock outputs.
   parameter int NUM_MEM  = 13   // Memory clock outputs.
) (
   input  wire logic                i_clk,                 // 200 MHz system clock.
   input  wire logic                i_resetn,              // Power-up reset, active low.
   input  wire logic                i_ctrl_clock_line,     // Serial clock pin level.
   input  wire logic                i_ctrl_data_line,      // Serial data pin level.
   output logic                     o_ctrl_data_line,      // Data drive, always 0.
   output logic                     o_ctrl_data_line_oe_n, // Low while pulling data low.
   input  wire logic                i_strap_freq_bit0_inv, // Strap pin, inverted bit 0.
   input  wire logic                i_strap_freq_bit1_inv, // Strap pin, inverted bit 1.
   input  wire logic                i_proc_stop_n,         // Processor clock stop.
   input  wire logic                i_bus_stop_n,          // Gated bus clock stop.
   input  wire logic                i_mem_stop_n,          // Memory clock stop.
   input  wire logic [3:0]          i_clk_src_level,       // Source clock levels per group.
   output logic [NUM_PROC-1:0]      o_proc_clock_en,       // Processor clock enables.
   output logic                     o_free_running_bus_clock_en, // Free-running bus clock.
   output logic [NUM_BUS-1:0]       o_bus_clock_en,        // Gated bus clock enables.
   output logic [NUM_MEM-1:0]       o_mem_clock_en,        // Memory clock enables.
   output logic                     o_usb48_clock_en,      // 48 MHz output enable.
   output logic                     o_sio_clock_en,        // 24/14 MHz output enable.
   output logic                     o_outputs_tristate,    // All clock outputs high-Z.
   output logic                     o_spread_enable,       // Spread modulation on.
   output logic                     o_spread_wide,         // 1: 0.5 %, 0: 0.25 % depth.
   output logic                     o_soft_select,         // Frequency from software code.
   output logic [3:0]               o_soft_freq_code,      // Software frequency code.
   output logic [1:0]               o_strap_latched        // Latched inverted straps.
);

   localparam int NUM_EN = NUM_PROC + 1 + NUM_BUS + NUM_MEM + 2;

   // ----------------------------------------------------------------------
   // Pin synchronisation.
   // ----------------------------------------------------------------------
   logic [1:0] line_s;
   logic [1:0] strap_s;
   logic [2:0] stop_s;
   logic [3:0] src_s;

   // Idle lines sit high; resetting high avoids a false start.
   line_sync #(.W(2), .RST_VAL(2'h3)) u_line_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_async  ({i_ctrl_data_line, i_ctrl_clock_line}),
      .o_sync   (line_s)
   );

   line_sync #(.W(9), .RST_VAL(9'h1FF)) u_misc_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_async  ({i_clk_src_level, i_mem_stop_n, i_bus_stop_n, i_proc_stop_n,
                  i_strap_freq_bit1_inv, i_strap_freq_bit0_inv}),
      .o_sync   ({src_s, stop_s, strap_s})
   );

   // ----------------------------------------------------------------------
   // Strap capture.
   // ----------------------------------------------------------------------
   logic [1:0] strap_ff;
   logic [1:0] settle_ff;
   logic       strap_done_ff;

   // Straps are caught once, after the synchroniser fills;
   // nothing but reset re-reads them.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         strap_ff      <= 2'h0;
         settle_ff     <= 2'h0;
         strap_done_ff <= 1'b0;
      end else if (!strap_done_ff) begin
         settle_ff <= settle_ff + 2'h1;
         if (settle_ff == STRAP_SETTLE_CYCLES) begin
            strap_ff      <= strap_s; // R12
            strap_done_ff <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Line event detection.
   // ----------------------------------------------------------------------
   logic scl_q_ff;
   logic sda_q_ff;

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= line_s[0];
         sda_q_ff <= line_s[1];
      end
   end

   wire scl      = line_s[0];
   wire sda      = line_s[1];
   wire scl_rise = scl & ~scl_q_ff;
   wire scl_fall = ~scl & scl_q_ff;
   // Data moves only with the clock low, so a data edge
   // with the clock high marks a frame.
   wire start_ev = scl & scl_q_ff & sda_q_ff & ~sda; // R5
   wire stop_ev  = scl & scl_q_ff & ~sda_q_ff & sda; // R5

   // ----------------------------------------------------------------------
   // Link state.
   // ----------------------------------------------------------------------
   link_state_t state_ff, nxt_state;
   byte_stage_t stage_ff, nxt_stage;
   logic [3:0]  bit_cnt_ff, nxt_bit_cnt;
   logic [7:0]  shift_ff, nxt_shift;
   logic [2:0]  ptr_ff, nxt_ptr;
   logic        read_ff, nxt_read;
   logic        oe_n_ff, nxt_oe_n;
   logic        drv_ff;

   reg_port_if regs ();

   wire byte_done  = (bit_cnt_ff == 4'h8);
   wire addr_match = (shift_ff[7:1] == SLAVE_ADDR7); // R7
   wire ptr_next_en = (ptr_ff <= IDX_LAST);
   wire [2:0] ptr_inc = ptr_next_en ? ptr_ff + 3'h1 : ptr_ff;

   // Data bytes are written at the fall opening their acknowledge.
   assign regs.wr_en   = (state_ff == ST_RX) && scl_fall && byte_done
                         && (stage_ff == STG_DATA) && !start_ev && !stop_ev; // R10
   assign regs.addr    = ptr_ff;
   assign regs.wr_data = shift_ff;

   // Slave next state. Frame markers win, so a repeated
   // start resynchronises the slave in any state.
   always_comb begin
      nxt_state   = state_ff;
      nxt_stage   = stage_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_shift   = shift_ff;
      nxt_ptr     = ptr_ff;
      nxt_read    = read_ff;
      nxt_oe_n    = oe_n_ff;
      if (start_ev) begin
         nxt_state   = ST_RX;
         nxt_stage   = STG_ADDR;
         nxt_bit_cnt = 4'h0;
         nxt_oe_n    = 1'b1;
      end else if (stop_ev) begin
         nxt_state = ST_IDLE;
         nxt_oe_n  = 1'b1;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               nxt_oe_n = 1'b1;
            end
            ST_RX: begin
               if (scl_rise && !byte_done) begin
                  nxt_shift   = {shift_ff[6:0], sda}; // R4
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
               end else if (scl_fall && byte_done) begin // R6
                  nxt_state = ST_ACK;
                  nxt_oe_n  = 1'b0; // R8
                  case (stage_ff)
                     STG_ADDR: begin
                        nxt_read = shift_ff[0];
                        nxt_ptr  = IDX_FREQ_SELECT_CONTROL; // R2
                        if (!addr_match) begin
                           nxt_state = ST_IDLE;
                           nxt_oe_n  = 1'b1;
                        end
                     end
                     STG_CMD:   nxt_stage = STG_COUNT; // R9
                     STG_COUNT: nxt_stage = STG_DATA;  // R9
                     STG_DATA:  nxt_ptr   = ptr_inc;   // R10
                     default:   nxt_stage = STG_DATA;
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  nxt_oe_n    = 1'b1;
                  nxt_bit_cnt = 4'h0;
                  nxt_state   = ST_RX;
                  if (stage_ff == STG_ADDR) begin
                     nxt_stage = STG_CMD;
                     if (read_ff == DIR_READ) begin // R11
                        nxt_state   = ST_TX;
                        nxt_shift   = regs.rd_data;      // R24
                        nxt_oe_n    = regs.rd_data[7];
                        nxt_bit_cnt = 4'h1;
                        nxt_ptr     = ptr_inc;
                     end
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (byte_done) begin
                     nxt_state = ST_MACK;
                     nxt_oe_n  = 1'b1;
                  end else begin
                     nxt_shift   = {shift_ff[6:0], 1'b0};
                     nxt_oe_n    = shift_ff[6]; // R4
                     nxt_bit_cnt = bit_cnt_ff + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               // A high acknowledge from the master ends the read.
               if (scl_rise) begin
                  nxt_state = sda ? ST_IDLE : ST_TXLOAD;
               end
            end
            ST_TXLOAD: begin
               if (scl_fall) begin
                  nxt_state   = ST_TX;
                  nxt_shift   = regs.rd_data; // R24
                  nxt_oe_n    = regs.rd_data[7];
                  nxt_bit_cnt = 4'h1;
                  nxt_ptr     = ptr_inc;
               end
            end
            default: begin
               nxt_state = ST_IDLE;
               nxt_oe_n  = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_ff   <= ST_IDLE;
         stage_ff   <= STG_ADDR;
         bit_cnt_ff <= 4'h0;
         shift_ff   <= 8'h00;
         ptr_ff     <= IDX_FREQ_SELECT_CONTROL;
         read_ff    <= 1'b0;
         oe_n_ff    <= 1'b1;
         drv_ff     <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         stage_ff   <= nxt_stage;
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff   <= nxt_shift;
         ptr_ff     <= nxt_ptr;
         read_ff    <= nxt_read;
         oe_n_ff    <= nxt_oe_n;
         drv_ff     <= 1'b0;
      end
   end

   // Open-drain pin: the slave only ever pulls low.
   assign o_ctrl_data_line      = drv_ff; // R1
   assign o_ctrl_data_line_oe_n = oe_n_ff;

   // ----------------------------------------------------------------------
   // Register bank.
   // ----------------------------------------------------------------------
   ctrl_reg_bank u_bank (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_straps (strap_ff),
      .port     (regs.bank)
   );

   wire [7:0] reg_fsc   = regs.contents[7:0];
   wire [7:0] reg_cpu   = regs.contents[15:8];
   wire [7:0] reg_pci   = regs.contents[23:16];
   wire [7:0] reg_mem   = regs.contents[31:24];
   wire [7:0] reg_extra = regs.contents[39:32];

   // ----------------------------------------------------------------------
   // Frequency and mode outputs.
   // ----------------------------------------------------------------------
   logic [7:0] fsc_ff;

   // A register copy keeps mode outputs on flops.
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         fsc_ff <= RST_FREQ_SELECT_CONTROL; // R3
      end else begin
         fsc_ff <= reg_fsc;
      end
   end

   assign o_outputs_tristate = fsc_ff[FSC_TRISTATE_BIT];  // R13
   assign o_spread_enable    = fsc_ff[FSC_SPREAD_EN_BIT]; // R14
   assign o_spread_wide      = fsc_ff[FSC_DEPTH_BIT];     // R23
   assign o_soft_select      = fsc_ff[FSC_SOFT_SEL_BIT];  // R15
   assign o_soft_freq_code   = {fsc_ff[FSC_CODE_MSB_BIT],
                                fsc_ff[FSC_CODE_LO_LSB+2:FSC_CODE_LO_LSB]}; // R16
   assign o_strap_latched    = strap_ff;

   // ----------------------------------------------------------------------
   // Output enable gating.
   // ----------------------------------------------------------------------
   // Order: processor, free bus, gated bus, memory, 48 MHz, 24/14 MHz.
   wire [NUM_EN-1:0] want_en = {
      reg_extra[EXTRA_SIO_BIT],                                      // R20
      reg_extra[EXTRA_USB_BIT],                                      // R20
      reg_extra[NUM_MEM-9:0] & {(NUM_MEM-8){stop_s[2]}},             // R22
      reg_mem & {8{stop_s[2]}},                                      // R19
      reg_pci[NUM_BUS-1:0] & {NUM_BUS{stop_s[1]}},                   // R18
      reg_pci[PCI_FREE_BIT],                                         // R18
      reg_cpu[CPU_EN_LSB+NUM_PROC-1:CPU_EN_LSB] & {NUM_PROC{stop_s[0]}} // R17
   };

   logic [NUM_EN-1:0] en_ff;

   // Enables move only while the source clock is low, so a
   // running high period completes before the output parks low.
   for (genvar i = 0; i < NUM_EN; i++) begin : g_gate
      localparam int GRP = (i < NUM_PROC) ? 0 :
                           (i < NUM_PROC + 1 + NUM_BUS) ? 1 :
                           (i < NUM_PROC + 1 + NUM_BUS + NUM_MEM) ? 2 : 3;
      always_ff @(posedge i_clk) begin
         if (!i_resetn) begin
            en_ff[i] <= 1'b1; // R3
         end else if (!src_s[GRP]) begin
            en_ff[i] <= want_en[i]; // R21
         end
      end
   end

   assign o_proc_clock_en             = en_ff[NUM_PROC-1:0];
   assign o_free_running_bus_clock_en = en_ff[NUM_PROC];
   assign o_bus_clock_en              = en_ff[NUM_PROC+NUM_BUS:NUM_PROC+1];
   assign o_mem_clock_en              = en_ff[NUM_EN-3:NUM_PROC+1+NUM_BUS];
   assign o_usb48_clock_en            = en_ff[NUM_EN-2];
   assign o_sio_clock_en              = en_ff[NUM_EN-1];

endmodule
`default_nettype wire

// File: ctrl_port_properties.sv
// Checker bound to the serial control port.
`timescale 1ns/10ps
`default_nettype none
module ctrl_port_properties #(
   parameter int NUM_PROC = 3, NUM_BUS = 5, NUM_MEM = 13
) (
   input wire logic i_clk, i_resetn, i_ctrl_clock_line, i_proc_stop_n, i_bus_stop_n,
   input wire logic i_mem_stop_n, i_strap_freq_bit0_inv, i_strap_freq_bit1_inv,
   input wire logic o_ctrl_data_line, o_ctrl_data_line_oe_n, o_outputs_tristate,
   input wire logic [3:0] i_clk_src_level,
   input wire logic [1:0] o_strap_latched,
   input wire logic [NUM_PROC-1:0] o_proc_clock_en,
   input wire logic [NUM_BUS-1:0] o_bus_clock_en,
   input wire logic [NUM_MEM-1:0] o_mem_clock_en
);
   // Eight held cycles cover synchroniser and enable latency.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_held(logic stop_n, logic src); (!stop_n && !src) [*8]; endsequence
   property p_drive; o_ctrl_data_line == 1'b0; endproperty
   a_drive: assert property (p_drive) else $error("data drive not low");
   property p_oe; $changed(o_ctrl_data_line_oe_n) |-> !i_ctrl_clock_line; endproperty
   a_oe: assert property (p_oe) else $error("data moved with clock high");
   property p_rst; disable iff (1'b0) !i_resetn |=> o_ctrl_data_line_oe_n &&
      !o_outputs_tristate && (&o_proc_clock_en) && (&o_mem_clock_en); endproperty
   a_rst: assert property (p_rst) else $error("bad reset value");
   property p_proc; s_held(i_proc_stop_n, i_clk_src_level[0]) |-> o_proc_clock_en == '0; endproperty
   a_proc: assert property (p_proc) else $error("proc clock not stopped");
   property p_bus; s_held(i_bus_stop_n, i_clk_src_level[1]) |-> o_bus_clock_en == '0; endproperty
   a_bus: assert property (p_bus) else $error("bus clock not stopped");
   property p_mem; s_held(i_mem_stop_n, i_clk_src_level[2]) |-> o_mem_clock_en == '0; endproperty
   a_mem: assert property (p_mem) else $error("mem clock not stopped");
   property p_high; i_clk_src_level[0] [*8] |=> $stable(o_proc_clock_en); endproperty
   a_high: assert property (p_high) else $error("enable moved in high phase");
   property p_strap; $rose(i_resetn) |-> ##10
      o_strap_latched == {i_strap_freq_bit1_inv, i_strap_freq_bit0_inv}; endproperty
   a_strap: assert property (p_strap) else $error("strap not latched");
endmodule
bind clock_gen_serial_control ctrl_port_properties #(.NUM_PROC(NUM_PROC), .NUM_BUS(NUM_BUS),
   .NUM_MEM(NUM_MEM)) props (.*);
`default_nettype wire

// File: two_wire_host.sv
// Two-wire bus master model.
`timescale 1ns/10ps
`default_nettype none
module two_wire_host (
   input  wire logic i_clk, i_sda,  // Clock and resolved data.
   output logic      o_scl = 1'b1,  // Serial clock, high when idle.
   output logic      o_sda = 1'b1   // Open-drain drive; 1 releases.
);
   // Eight clocks a phase, four phases a 160 ns bit.
   task automatic ph(input logic d, c);
      o_sda = d;
      o_scl = c;
      repeat (8) @(negedge i_clk);
   endtask
   // Data falls, then rises, only with the clock high.
   task automatic start();
      ph(1'b0, 1'b1);
      ph(1'b0, 1'b0);
   endtask
   task automatic stop();
      ph(1'b0, 1'b0);
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
   endtask
   // Byte MSB first, then the acknowledge slot.
   task automatic xfer(input logic [8:0] v, output logic [8:0] s);
      for (int i = 8; i >= 0; i--) begin
         ph(v[i], 1'b0);
         ph(v[i], 1'b1);
         ph(v[i], 1'b1);
         s[i] = i_sda;
         ph(v[i], 1'b0);
      end
   endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the serial control port.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic i_clk = 1'b0, i_resetn = 1'b0, i_proc_stop_n = 1'b1, i_bus_stop_n = 1'b1;
   logic i_mem_stop_n = 1'b1, i_strap_freq_bit0_inv = 1'b1, i_strap_freq_bit1_inv = 1'b0;
   logic o_ctrl_data_line, o_ctrl_data_line_oe_n, o_free_running_bus_clock_en;
   logic o_usb48_clock_en, o_sio_clock_en, o_outputs_tristate, o_spread_enable;
   logic o_spread_wide, o_soft_select, i_ctrl_clock_line, sda_drive;
   logic [3:0] i_clk_src_level = 4'h0, o_soft_freq_code;
   logic [2:0] o_proc_clock_en;
   logic [4:0] o_bus_clock_en;
   logic [12:0] o_mem_clock_en;
   logic [1:0] o_strap_latched;
   logic [8:0] s;
   logic [7:0] wr [6] = '{8'hD2, 8'h00, 8'h00, 8'hDF, 8'h0A, 8'h00};
   int fails = 0, checks_done = 0, cycles = 0;
   // Pulled-up open-drain data wire.
   wire logic i_ctrl_data_line = sda_drive & (o_ctrl_data_line_oe_n | o_ctrl_data_line);
   wire logic [7:0] mode = {o_outputs_tristate, o_spread_enable, o_soft_select, o_spread_wide,
      o_soft_freq_code};
   clock_gen_serial_control dut (.*);
   two_wire_host host (.i_clk, .i_sda(i_ctrl_data_line), .o_scl(i_ctrl_clock_line),
      .o_sda(sda_drive));
   always #2.5 i_clk = ~i_clk;
   // Tests need about 3100 cycles.
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   initial begin
      repeat (10) @(negedge i_clk);
      i_resetn = 1'b1;
      repeat (12) @(negedge i_clk);
      chk({o_strap_latched, o_proc_clock_en, o_bus_clock_en, o_free_running_bus_clock_en},
         16'h03FF);
      chk({o_mem_clock_en, o_usb48_clock_en, o_sio_clock_en}, 16'h7FFF);
      chk(mode, 16'h0000);
      host.start();
      host.xfer({8'hD4, 1'b1}, s);
      chk(s[0], 1'b1);
      host.stop();
      $display("test defaults done");
      host.start();
      foreach (wr[i]) begin
         host.xfer({wr[i], 1'b1}, s);
         chk(s[0], 1'b0);
      end
      host.stop();
      repeat (20) @(negedge i_clk);
      chk(mode, 16'h00FD);
      chk({o_proc_clock_en, o_bus_clock_en, o_free_running_bus_clock_en}, 16'h0140);
      $display("test write done");
      i_clk_src_level = 4'hF;
      host.start();
      host.xfer({8'hD3, 1'b1}, s);
      chk(s[0], 1'b0);
      host.xfer({8'hFF, 1'b0}, s);
      chk(s[8:1], 8'hDF);
      host.xfer({8'hFF, 1'b1}, s);
      chk(s[8:1], 8'hFB);
      host.stop();
      i_clk_src_level = 4'h0;
      $display("test read back done");
      {i_proc_stop_n, i_bus_stop_n, i_mem_stop_n} = 3'h0;
      repeat (20) @(negedge i_clk);
      chk({o_proc_clock_en, o_mem_clock_en}, 16'h0000);
      {i_proc_stop_n, i_bus_stop_n, i_mem_stop_n} = 3'h7;
      repeat (20) @(negedge i_clk);
      chk({o_proc_clock_en, o_mem_clock_en}, 16'hBFFF);
      $display("test stop pins done");
      results();
   end
endmodule
`default_nettype wire
